// *** hw/acc_top.sv ***
// analog comparator control: registers, input routing, interrupt sensing
//
// The strobed register port was chosen for this implementation.
module acc_top
    import acc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        comparator_result,
    output logic             negative_from_pin,
    output logic             positive_from_ladder,
    output logic             ladder_power,
    output logic             ladder_range,
    output logic      [3:0]  ladder_tap,
    output logic             comparator_output_pin_o,
    output logic             comparator_output_pin_oe,
    output logic             cmp_irq
);
    // --------------------------------------------------
    // state
    // --------------------------------------------------
    logic        sync1_ff;
    logic        sync2_ff;
    logic        prev_ff;
    logic [1:0]  src_ff;
    logic [1:0]  sense_ff;
    logic        lvl_ff;
    logic        inv_ff;
    logic        pino_ff;
    logic        ref_en_ff;
    logic        range_ff;
    logic [3:0]  tap_ff;
    logic        irq_en_ff;
    logic        raw_ff;
    logic [31:0] rdata_ff;
    logic        neg_ff;
    logic        pos_ff;
    logic        pwr_ff;
    logic        rngo_ff;
    logic [3:0]  tapo_ff;
    logic        pin_ff;
    logic        pin_oe_ff;
    logic        irq_ff;

    logic        nxt_sync1;
    logic        nxt_sync2;
    logic        nxt_prev;
    logic [1:0]  nxt_src;
    logic [1:0]  nxt_sense;
    logic        nxt_lvl;
    logic        nxt_inv;
    logic        nxt_pino;
    logic        nxt_ref_en;
    logic        nxt_range;
    logic [3:0]  nxt_tap;
    logic        nxt_irq_en;
    logic        nxt_raw;
    logic [31:0] nxt_rdata;
    logic        nxt_neg;
    logic        nxt_pos;
    logic        nxt_pwr;
    logic        nxt_rngo;
    logic [3:0]  nxt_tapo;
    logic        nxt_pin;
    logic        nxt_pin_oe;
    logic        nxt_irq;

    logic        proc_val;
    logic        rise;
    logic        fall;
    logic        event_set;
    logic        wr_ctl;
    logic        wr_ref;
    logic        wr_clr;

    // --------------------------------------------------
    // input conditioning
    // --------------------------------------------------
    // inversion sits after the synchroniser, so a toggle of
    // the invert bit looks like an edge; software masks first
    always_comb
    begin
        nxt_sync1 = comparator_result;
        nxt_sync2 = sync1_ff;                   // see RL20
        proc_val  = sync2_ff ^ inv_ff;          // see RL7
        nxt_prev  = proc_val;
        rise      = proc_val & ~prev_ff;        // see RL20
        fall      = ~proc_val & prev_ff;
    end

    // --------------------------------------------------
    // interrupt sensing
    // --------------------------------------------------
    always_comb
    begin
        case (sense_ff)                         // see RL4
            SNS_LEVEL: event_set = (proc_val == lvl_ff); // see RL6
            SNS_FALL:  event_set = fall;        // see RL5
            SNS_RISE:  event_set = rise;
            SNS_BOTH:  event_set = rise | fall;
            default:   event_set = 1'h0;
        endcase
        wr_clr  = reg_wr && (reg_addr == OFS_MASKED)
                  && reg_wdata[IRQ_BIT];
        // a new event in the clear cycle wins
        nxt_raw = event_set | (raw_ff & ~wr_clr); // see RL21
        nxt_irq = raw_ff & irq_en_ff;           // see RL10
    end

    // --------------------------------------------------
    // register writes
    // --------------------------------------------------
    always_comb
    begin
        wr_ctl     = reg_wr && (reg_addr == OFS_CTL);
        wr_ref     = reg_wr && (reg_addr == OFS_REF_CTL);
        nxt_src    = src_ff;
        nxt_sense  = sense_ff;
        nxt_lvl    = lvl_ff;
        nxt_inv    = inv_ff;
        nxt_pino   = pino_ff;
        nxt_ref_en = ref_en_ff;
        nxt_range  = range_ff;
        nxt_tap    = tap_ff;
        nxt_irq_en = irq_en_ff;
        if (wr_ctl)
        begin
            nxt_src   = reg_wdata[CTL_SRC_LSB +: 2];
            nxt_sense = reg_wdata[CTL_SNS_LSB +: 2];
            nxt_lvl   = reg_wdata[CTL_LVL_BIT];
            nxt_inv   = reg_wdata[CTL_INV_BIT];
            nxt_pino  = reg_wdata[CTL_PINO_BIT];
        end
        else if (wr_ref)
        begin
            nxt_ref_en = reg_wdata[REF_EN_BIT];  // see RL11
            nxt_range  = reg_wdata[RANGE_BIT];   // see RL13
            nxt_tap    = reg_wdata[REF_TAP_LSB +: 4]; // see RL14
        end
        else if (reg_wr && (reg_addr == OFS_IRQ_EN))
        begin
            nxt_irq_en = reg_wdata[IRQ_BIT];
        end
    end

    // --------------------------------------------------
    // register reads
    // --------------------------------------------------
    always_comb
    begin
        nxt_rdata = REG_RESET;
        if (!reg_rd)
        begin
            nxt_rdata = REG_RESET;
        end
        else if (reg_addr == OFS_MASKED)        // see RL18
        begin
            nxt_rdata[IRQ_BIT] = raw_ff & irq_en_ff; // see RL10
        end
        else if (reg_addr == OFS_RAW)
        begin
            nxt_rdata[IRQ_BIT] = raw_ff;        // see RL9
        end
        else if (reg_addr == OFS_IRQ_EN)
        begin
            nxt_rdata[IRQ_BIT] = irq_en_ff;
        end
        else if (reg_addr == OFS_REF_CTL)
        begin
            nxt_rdata[REF_EN_BIT]       = ref_en_ff;
            nxt_rdata[RANGE_BIT]        = range_ff;
            nxt_rdata[REF_TAP_LSB +: 4] = tap_ff;
        end
        else if (reg_addr == OFS_STATUS)
        begin
            nxt_rdata[VALUE_BIT] = proc_val;    // see RL8
        end
        else if (reg_addr == OFS_CTL)
        begin
            nxt_rdata[CTL_SRC_LSB +: 2] = src_ff;
            nxt_rdata[CTL_SNS_LSB +: 2] = sense_ff;
            nxt_rdata[CTL_LVL_BIT]      = lvl_ff;
            nxt_rdata[CTL_INV_BIT]      = inv_ff;
            nxt_rdata[CTL_PINO_BIT]     = pino_ff;
        end
    end

    // --------------------------------------------------
    // analog steering outputs
    // --------------------------------------------------
    // with the ladder off the tap and range are forced to the
    // quietest ground setting, whatever software left there
    always_comb
    begin
        nxt_neg    = 1'h1;                      // see RL1
        nxt_pos    = (src_ff == SRC_LADDER);    // see RL2
        nxt_pwr    = ref_en_ff;                 // see RL11
        nxt_rngo   = ref_en_ff ? range_ff : 1'h1; // see RL12
        nxt_tapo   = ref_en_ff ? tap_ff : TAP_RESET; // see RL12
        nxt_pin    = pino_ff & proc_val;        // see RL3
        nxt_pin_oe = pino_ff;                   // see RL3
    end

    // --------------------------------------------------
    // flip-flops
    // --------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sync1_ff  <= 1'h0;
            sync2_ff  <= 1'h0;
            prev_ff   <= 1'h0;
            src_ff    <= 2'h0;
            sense_ff  <= SNS_LEVEL;
            lvl_ff    <= 1'h0;
            inv_ff    <= 1'h0;
            pino_ff   <= 1'h0;
            ref_en_ff <= 1'h0;
            range_ff  <= 1'h0;
            tap_ff    <= TAP_RESET;
            irq_en_ff <= 1'h0;
            raw_ff    <= 1'h0;
            rdata_ff  <= REG_RESET;
            neg_ff    <= 1'h1;
            pos_ff    <= 1'h0;
            pwr_ff    <= 1'h0;
            rngo_ff   <= 1'h1;
            tapo_ff   <= TAP_RESET;
            pin_ff    <= 1'h0;
            pin_oe_ff <= 1'h0;
            irq_ff    <= 1'h0;
        end
        else
        begin
            sync1_ff  <= nxt_sync1;
            sync2_ff  <= nxt_sync2;
            prev_ff   <= nxt_prev;
            src_ff    <= nxt_src;
            sense_ff  <= nxt_sense;
            lvl_ff    <= nxt_lvl;
            inv_ff    <= nxt_inv;
            pino_ff   <= nxt_pino;
            ref_en_ff <= nxt_ref_en;
            range_ff  <= nxt_range;
            tap_ff    <= nxt_tap;
            irq_en_ff <= nxt_irq_en;
            raw_ff    <= nxt_raw;
            rdata_ff  <= nxt_rdata;
            neg_ff    <= nxt_neg;
            pos_ff    <= nxt_pos;
            pwr_ff    <= nxt_pwr;
            rngo_ff   <= nxt_rngo;
            tapo_ff   <= nxt_tapo;
            pin_ff    <= nxt_pin;
            pin_oe_ff <= nxt_pin_oe;
            irq_ff    <= nxt_irq;
        end
    end

    assign reg_rdata                = rdata_ff;
    assign negative_from_pin        = neg_ff;
    assign positive_from_ladder     = pos_ff;
    assign ladder_power             = pwr_ff;
    assign ladder_range             = rngo_ff;
    assign ladder_tap               = tapo_ff;
    assign comparator_output_pin_o  = pin_ff;
    assign comparator_output_pin_oe = pin_oe_ff;
    assign cmp_irq                  = irq_ff;

    // --------------------------------------------------
    // assertions
    // --------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence seq_wr_ctl_ladder;
        wr_ctl && reg_wdata[CTL_SRC_LSB +: 2] == SRC_LADDER;
    endsequence

    sequence seq_rise_armed;
        sense_ff == SNS_RISE && rise;
    endsequence

    sequence seq_clear_idle;
        wr_clr && !event_set;
    endsequence

    AST_NEG_PIN: assert property (negative_from_pin) // see RL1
        else $error("negative input left the pin");
    AST_SRC_LADDER: assert property (                // see RL2
        seq_wr_ctl_ladder ##1 !wr_ctl |=> positive_from_ladder)
        else $error("ladder source not routed");
    AST_PIN_OUT: assert property (                   // see RL3
        !pino_ff |=> !comparator_output_pin_oe)
        else $error("pin driven while output off");
    AST_RISE_SET: assert property (                  // see RL5
        seq_rise_armed |=> raw_ff)
        else $error("rising edge not latched");
    AST_LEVEL: assert property (                     // see RL6
        sense_ff == SNS_LEVEL && proc_val != lvl_ff
        && !$past(raw_ff) && !raw_ff |=> !raw_ff)
        else $error("level set with wrong polarity");
    AST_INVERT: assert property (                    // see RL7
        pino_ff |=> comparator_output_pin_o
                    == ($past(sync2_ff) ^ $past(inv_ff)))
        else $error("inversion wrong on pin");
    AST_STATUS: assert property (                    // see RL8
        reg_rd && reg_addr == OFS_STATUS
        |=> reg_rdata[VALUE_BIT] == $past(proc_val))
        else $error("status value wrong");
    AST_MASKED: assert property (                    // see RL10
        raw_ff && irq_en_ff |=> cmp_irq)
        else $error("enabled interrupt not signalled");
    AST_LADDER_GND: assert property (                // see RL12
        !ladder_power |-> ladder_tap == TAP_RESET && ladder_range)
        else $error("ladder not quiet while off");
    AST_CLEAR: assert property (                     // see RL21
        seq_clear_idle |=> !raw_ff)
        else $error("raw flag not cleared");
endmodule : acc_top

// *** hw/acc_pkg.sv ***
// constants and register map of the analog comparator control block
// Functional notes
// RL1: negative input always from negative pin
// RL2: source 00/01 pin, 10 ladder, 11 reserved
// RL3: result optionally driven to output pin
// RL4: sense field picks level or edge interrupt
// RL5: sense 00 level, 01 fall, 10 rise, 11 both
// RL6: level polarity picks low or high level
// RL7: invert bit complements output before processing
// RL8: status register shows present output value
// RL9: raw status shows condition regardless of enable
// RL10: enable gates raw into masked status, irq
// RL11: ladder power bit 9 enables ladder
// RL12: disabled ladder gives ground reference
// RL13: range bit 8 selects 32R+8 or 24R
// RL14: four-bit tap field steers ladder mux
// RL15: software enables clock gate first
// RL16: software writes 0x30C for 1.65 V
// RL17: software writes 0x40C, waits, reads value
// RL18: registers sit at listed offsets
// RL19: software disables pad digital input buffer
// RL20: synchronise output, edge is change vs previous
// RL21: write one to masked bit clears raw
package acc_pkg;
    // --------------------------------------------------
    // register offsets
    // --------------------------------------------------
    localparam logic [7:0] OFS_MASKED  = 8'h00;
    localparam logic [7:0] OFS_RAW     = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h08;
    localparam logic [7:0] OFS_REF_CTL = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h20;
    localparam logic [7:0] OFS_CTL     = 8'h24;
    // --------------------------------------------------
    // field positions
    // --------------------------------------------------
    localparam int IRQ_BIT      = 0;
    localparam int VALUE_BIT    = 1;
    localparam int REF_EN_BIT   = 9;
    localparam int RANGE_BIT    = 8;
    localparam int REF_TAP_LSB  = 0;
    localparam int CTL_PINO_BIT = 11;
    localparam int CTL_SRC_LSB  = 9;
    localparam int CTL_LVL_BIT  = 4;
    localparam int CTL_SNS_LSB  = 2;
    localparam int CTL_INV_BIT  = 1;
    // --------------------------------------------------
    // reset values and encodings
    // --------------------------------------------------
    localparam logic [31:0] REG_RESET  = 32'h0000_0000;
    localparam logic [1:0]  SRC_LADDER = 2'h2;
    localparam logic [1:0]  SNS_LEVEL  = 2'h0;
    localparam logic [1:0]  SNS_FALL   = 2'h1;
    localparam logic [1:0]  SNS_RISE   = 2'h2;
    localparam logic [1:0]  SNS_BOTH   = 2'h3;
    localparam logic [3:0]  TAP_RESET  = 4'h0;
endpackage : acc_pkg

// *** tb/acc_cmp_model.sv ***
// behavioural model of the analog comparator core and its reference ladder
module acc_cmp_model
(
    input  wire logic        positive_from_ladder,
    input  wire logic        negative_from_pin,
    input  wire logic        ladder_power,
    input  wire logic        ladder_range,
    input  wire logic [3:0]  ladder_tap,
    input  wire logic [15:0] positive_pin_mv,
    input  wire logic [15:0] negative_pin_mv,
    output logic             comparator_result
);
    timeunit 1ns;
    timeprecision 1ps;
    // supply value is a plain default, voltages are whole millivolts
    // pads are seen as analog levels only, digital input buffer off
    localparam int AVDD_MV = 3300;
    int vref;
    int vplus;
    int vminus;
    always_comb
    begin
        if (!ladder_power)
            vref = 0;
        else if (ladder_range)
            vref = AVDD_MV * int'(ladder_tap) / 24;
        else
            vref = AVDD_MV * (int'(ladder_tap) + 8) / 32;
        vplus = positive_from_ladder ? vref : int'(positive_pin_mv);
        // an unconnected negative terminal floats: model it as the plus value mirrored about half the supply
        vminus = negative_from_pin ? int'(negative_pin_mv) : AVDD_MV - vplus;
        comparator_result = (vplus > vminus);
    end
endmodule : acc_cmp_model

// *** tb/acc_top_tb.sv ***
// self-checking testbench of the analog comparator control block
module acc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    localparam logic [15:0] MV_LOW  = 16'h03E8;
    localparam logic [15:0] MV_HIGH = 16'h07D0;
    localparam logic [7:0]  OFFS [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h24, 8'h0C};
    logic        sys_clk   = 1'h0;
    logic        reset     = 1'h1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'h0;
    logic        reg_rd    = 1'h0;
    logic [15:0] neg_mv    = MV_HIGH;
    logic [31:0] reg_rdata;
    logic        comparator_result;
    logic        negative_from_pin;
    logic        positive_from_ladder;
    logic        ladder_power;
    logic        ladder_range;
    logic [3:0]  ladder_tap;
    logic        pin_o;
    logic        pin_oe;
    logic        cmp_irq;
    int          bad_count = 0;
    int          checks    = 0;
    int          cycles    = 0;
    // ----------------------------------------
    // design, far side and clock
    // ----------------------------------------
    acc_top DUT (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .comparator_result(comparator_result), .negative_from_pin(negative_from_pin),
        .positive_from_ladder(positive_from_ladder), .ladder_power(ladder_power),
        .ladder_range(ladder_range), .ladder_tap(ladder_tap),
        .comparator_output_pin_o(pin_o), .comparator_output_pin_oe(pin_oe), .cmp_irq(cmp_irq));
    acc_cmp_model u_model (.positive_from_ladder(positive_from_ladder),
        .negative_from_pin(negative_from_pin), .ladder_power(ladder_power),
        .ladder_range(ladder_range), .ladder_tap(ladder_tap), .positive_pin_mv(16'h0000),
        .negative_pin_mv(neg_mv), .comparator_result(comparator_result));
    always #2.5 sys_clk = ~sys_clk;
    // whole run needs about 350 cycles; over ten times that means a hang
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            conclude();
        end
    end
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_reg
    task automatic chk_pin(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_pin
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge sys_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'h0;
        #1 chk_reg(name, exp, reg_rdata);
    endtask : rd
    // long enough for sync flops, edge flag and interrupt register
    task automatic settle();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic drive(input logic [15:0] mv);
        @(posedge sys_clk);
        neg_mv <= mv;
        settle();
    endtask : drive
    task automatic conclude();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'h0;
        settle();
        chk_pin("negative_from_pin", 1'h1, negative_from_pin);
        chk_pin("ladder_power", 1'h0, ladder_power);
        chk_pin("ladder_range", 1'h1, ladder_range);
        // output starts low under level sense, polarity 0: raw flag sets at once
        foreach (OFFS[i])
            rd(OFFS[i], {31'h0, OFFS[i] == OFS_RAW}, "reset value");
        wr(OFS_REF_CTL, 32'hFFFF_FFFF);
        rd(OFS_REF_CTL, 32'h0000_030F, "ref ctl");
        wr(OFS_REF_CTL, 32'h0000_000F);
        settle();
        chk_pin("ladder_power", 1'h0, ladder_power);
        chk_reg("ladder_tap", 32'h0, {28'h0, ladder_tap});
        wr(OFS_REF_CTL, 32'h0000_020F);
        settle();
        chk_pin("ladder_range", 1'h0, ladder_range);
        chk_reg("ladder_tap", 32'hF, {28'h0, ladder_tap});
        wr(OFS_REF_CTL, 32'h0000_030C);
        wr(OFS_CTL, 32'h0000_040C);
        settle();
        chk_pin("from_ladder", 1'h1, positive_from_ladder);
        chk_pin("pin_oe", 1'h0, pin_oe);
        rd(OFS_CTL, 32'h0000_040C, "ctl");
        // rise sense, output stays low: the latched raw flag must survive
        wr(OFS_CTL, 32'h0000_0208);
        settle();
        chk_pin("from_ladder", 1'h0, positive_from_ladder);
        wr(OFS_RAW, 32'h0000_0001);
        rd(OFS_RAW, 32'h0000_0001, "raw after write");
        wr(OFS_CTL, 32'h0000_0C00);
        drive(MV_LOW);
        chk_pin("pin_oe", 1'h1, pin_oe);
        chk_pin("pin_o", 1'h1, pin_o);
        rd(OFS_STATUS, 32'h0000_0002, "status");
        wr(OFS_CTL, 32'h0000_0C02);
        settle();
        chk_pin("pin_o", 1'h0, pin_o);
        rd(OFS_STATUS, 32'h0, "status inverted");
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_CTL, 32'h0000_0410 | (s << 2));
            drive(MV_HIGH);
            wr(OFS_MASKED, 32'h0000_0001);
            settle();
            rd(OFS_RAW, 32'h0, "raw idle low");
            drive(MV_LOW);
            rd(OFS_RAW, {31'h0, (s != 1)}, "raw rise");
            wr(OFS_MASKED, 32'h0000_0001);
            settle();
            rd(OFS_RAW, {31'h0, (s == 0)}, "raw held high");
            drive(MV_HIGH);
            rd(OFS_RAW, {31'h0, (s != 2)}, "raw fall");
        end
        wr(OFS_CTL, 32'h0000_0400);
        wr(OFS_MASKED, 32'h0000_0001);
        settle();
        rd(OFS_RAW, 32'h0000_0001, "raw level low");
        rd(OFS_MASKED, 32'h0, "masked off");
        chk_pin("cmp_irq", 1'h0, cmp_irq);
        wr(OFS_IRQ_EN, 32'h0000_0001);
        settle();
        rd(OFS_MASKED, 32'h0000_0001, "masked on");
        chk_pin("cmp_irq", 1'h1, cmp_irq);
        rd(OFS_IRQ_EN, 32'h0000_0001, "irq enable");
        wr(OFS_CTL, 32'h0000_0408);
        wr(OFS_MASKED, 32'h0000_0001);
        settle();
        rd(OFS_RAW, 32'h0, "raw rise armed");
        drive(MV_LOW);
        wr(OFS_MASKED, 32'h0);
        settle();
        rd(OFS_RAW, 32'h0000_0001, "raw kept");
        wr(OFS_MASKED, 32'h0000_0001);
        settle();
        rd(OFS_RAW, 32'h0, "raw cleared");
        chk_pin("cmp_irq", 1'h0, cmp_irq);
        conclude();
    end
endmodule : acc_top_tb
